//--- src/sad_decoder.sv
// system address decoder: processor bus to memory and peripheral selects
// assumes one request at a time, held until done pulses
`timescale 1ns/10ps
`default_nettype none
module sad_decoder
  import sad_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               resetn,
  // request from the processor bus
  input  wire logic               req,
  input  wire logic               req_write,
  input  wire logic [31:0]        req_addr,
  input  wire logic [31:0]        req_wdata,
  // answer to the processor bus
  output logic                    rsp_done,
  output logic                    rsp_fault,
  output logic [31:0]             rsp_rdata,
  // toward the slaves
  output logic [NUM_SEL-1:0]      slv_sel,
  output logic                    slv_write,
  output logic [31:0]             slv_offset,
  output logic [31:0]             slv_wdata,
  // slave answer
  input  wire logic               slv_ready,
  input  wire logic [31:0]        slv_rdata
);

  logic [NUM_SEL-1:0] map_sel;
  logic [31:0]        map_offset;
  logic               map_alias;
  logic [31:0]        map_taddr;
  logic [4:0]         map_tbit;
  logic               map_fault;
  logic [NUM_SEL-1:0] tgt_sel;
  logic [31:0]        tgt_offset;
  logic               tgt_fault;
  logic               bb_wr;
  logic [31:0]        bb_word;
  logic               bb_done;
  logic [31:0]        bb_rdata;

  // decode of the request address
  sad_region_map u_map (
    .addr        (req_addr),
    .sel         (map_sel),
    .offset      (map_offset),
    .is_alias    (map_alias),
    .target_addr (map_taddr),
    .target_bit  (map_tbit),
    .fault       (map_fault)
  );

  // decode of the aliased target word
  sad_region_map u_tgt (
    .addr        (map_taddr),
    .sel         (tgt_sel),
    .offset      (tgt_offset),
    .is_alias    (),
    .target_addr (),
    .target_bit  (),
    .fault       (tgt_fault)
  );

  sad_xfer_t   kind;
  sad_xfer_t   next_kind;
  logic        busy;
  logic        next_busy;
  logic        next_done;
  logic        next_fault;
  logic [31:0] next_rdata;
  logic [NUM_SEL-1:0] next_sel;
  logic        next_write;
  logic [31:0] next_offset;
  logic [31:0] next_wdata;
  logic        bb_start;

  // alias to an unbacked target bit faults like the target would
  // same take condition as the control below, or a held request restarts it
  assign bb_start = req & ~busy & ~rsp_done & map_alias & ~tgt_fault;

  sad_bitband u_bb (
    .clk       (clk),
    .resetn    (resetn),
    .start     (bb_start),
    .write     (req_write),
    .wbit      (req_wdata[0]),
    .bitpos    (map_tbit),
    .slv_ready (slv_ready),
    .slv_rdata (slv_rdata),
    .wr_phase  (bb_wr),
    .wr_word   (bb_word),
    .done      (bb_done),
    .rdata     (bb_rdata)
  );

  // transfer control; outputs all registered
  always_comb
  begin
    next_kind   = kind;
    next_busy   = busy;
    next_done   = 1'b0;
    next_fault  = 1'b0;
    next_rdata  = rsp_rdata;
    next_sel    = slv_sel;
    next_write  = slv_write;
    next_offset = slv_offset;
    next_wdata  = slv_wdata;
    case (kind)
      SAD_XFER_NONE:
        if (req && !rsp_done)
        begin
          next_busy = 1'b1;
          if (map_fault || (map_alias && tgt_fault))
            next_kind = SAD_XFER_FAULT;
          else if (map_alias)
          begin
            next_kind   = SAD_XFER_BIT;
            next_sel    = tgt_sel;
            next_offset = tgt_offset;
            next_write  = 1'b0;
          end
          else
          begin
            next_kind   = SAD_XFER_WORD;
            next_sel    = map_sel;
            next_offset = map_offset;
            next_write  = req_write;
            next_wdata  = req_wdata;
          end
        end
      SAD_XFER_FAULT:
      begin
        next_done  = 1'b1;
        next_fault = 1'b1;
        next_rdata = '0;
        next_kind  = SAD_XFER_NONE;
        next_busy  = 1'b0;
      end
      SAD_XFER_WORD:
        if (slv_ready)
        begin
          next_done  = 1'b1;
          next_rdata = slv_rdata;
          next_sel   = '0;
          next_write = 1'b0;
          next_kind  = SAD_XFER_NONE;
          next_busy  = 1'b0;
        end
      SAD_XFER_BIT:
      begin
        next_write = bb_wr;
        next_wdata = bb_word;
        if (bb_done)
        begin
          next_done  = 1'b1;
          next_rdata = bb_rdata;
          next_sel   = '0;
          next_write = 1'b0;
          next_kind  = SAD_XFER_NONE;
          next_busy  = 1'b0;
        end
      end
      default:
        next_kind = SAD_XFER_NONE;
    endcase
  end

  // registers; done holds off a second take in the answer cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      kind       <= SAD_XFER_NONE;
      busy       <= 1'b0;
      rsp_done   <= 1'b0;
      rsp_fault  <= 1'b0;
      rsp_rdata  <= '0;
      slv_sel    <= '0;
      slv_write  <= 1'b0;
      slv_offset <= '0;
      slv_wdata  <= '0;
    end
    else
    begin
      kind       <= next_kind;
      busy       <= next_busy;
      rsp_done   <= next_done;
      rsp_fault  <= next_fault;
      rsp_rdata  <= next_rdata;
      slv_sel    <= next_sel;
      slv_write  <= next_write;
      slv_offset <= next_offset;
      slv_wdata  <= next_wdata;
    end
  end

endmodule // sad_decoder
`default_nettype wire

//--- src/sad_pkg.sv
// package for the system address decoder: region bounds, slave selects
// assumes a 32-bit byte address from the processor bus master
package sad_pkg;

  // memory regions
  localparam logic [31:0] FLASH_BASE      = 32'h0000_0000;
  localparam logic [31:0] FLASH_LAST      = 32'h0000_3fff;
  localparam logic [31:0] CODE_LAST       = 32'h1fff_ffff;
  localparam logic [31:0] SRAM_BASE       = 32'h2000_0000;
  localparam logic [31:0] SRAM_LAST       = 32'h2000_0fff;
  localparam logic [31:0] SRAM_BAND_LAST  = 32'h200f_ffff;
  localparam logic [31:0] SRAM_ALIAS_BASE = 32'h2200_0000;
  localparam logic [31:0] SRAM_ALIAS_LAST = 32'h23ff_ffff;
  localparam logic [31:0] PERI_BASE       = 32'h4000_0000;
  localparam logic [31:0] PERI_LAST       = 32'h400f_ffff;
  localparam logic [31:0] PERI_ALIAS_BASE = 32'h4200_0000;
  localparam logic [31:0] PERI_ALIAS_LAST = 32'h43ff_ffff;

  // private peripheral bus windows
  localparam logic [31:0] ITU_BASE  = 32'he000_0000;
  localparam logic [31:0] ITU_LAST  = 32'he000_0fff;
  localparam logic [31:0] WTU_BASE  = 32'he000_1000;
  localparam logic [31:0] WTU_LAST  = 32'he000_1fff;
  localparam logic [31:0] PBU_BASE  = 32'he000_2000;
  localparam logic [31:0] PBU_LAST  = 32'he000_2fff;
  localparam logic [31:0] VIC_BASE  = 32'he000_e000;
  localparam logic [31:0] VIC_LAST  = 32'he000_efff;
  localparam logic [31:0] TPU_BASE  = 32'he004_0000;
  localparam logic [31:0] TPU_LAST  = 32'he004_0fff;
  localparam logic [31:0] VEND_BASE = 32'he010_0000;

  // alias word to bit: offset = byte_off*32 + bit*4
  localparam int ALIAS_BIT_LSB  = 2;
  localparam int ALIAS_BYTE_LSB = 5;

  // slave selects, one hot position
  localparam int SEL_FLASH    = 0;
  localparam int SEL_SRAM     = 1;
  localparam int SEL_WDOG     = 2;
  localparam int SEL_GPIOA    = 3;
  localparam int SEL_GPIOB    = 4;
  localparam int SEL_GPIOC    = 5;
  localparam int SEL_GPIOD    = 6;
  localparam int SEL_SSP      = 7;
  localparam int SEL_UART0    = 8;
  localparam int SEL_UART1    = 9;
  localparam int SEL_I2CM     = 10;
  localparam int SEL_I2CS     = 11;
  localparam int SEL_GPIOE    = 12;
  localparam int SEL_TIMER0   = 13;
  localparam int SEL_TIMER1   = 14;
  localparam int SEL_TIMER2   = 15;
  localparam int SEL_COMP     = 16;
  localparam int SEL_FLASHCTL = 17;
  localparam int SEL_SYSCTL   = 18;
  localparam int SEL_ITU      = 19;
  localparam int SEL_WTU      = 20;
  localparam int SEL_PBU      = 21;
  localparam int SEL_VIC      = 22;
  localparam int SEL_TPU      = 23;
  localparam int NUM_SEL      = 24;

  // peripheral table: base and last of each select from SEL_WDOG to SEL_SYSCTL
  localparam int NUM_PERI = 17;
  localparam logic [31:0] PERI_TAB_BASE [NUM_PERI] = '{
    32'h4000_0000, 32'h4000_4000, 32'h4000_5000, 32'h4000_6000,
    32'h4000_7000, 32'h4000_8000, 32'h4000_c000, 32'h4000_d000,
    32'h4002_0000, 32'h4002_0800, 32'h4002_4000, 32'h4003_0000,
    32'h4003_1000, 32'h4003_2000, 32'h4003_c000, 32'h400f_d000,
    32'h400f_e000};
  localparam logic [31:0] PERI_TAB_LAST [NUM_PERI] = '{
    32'h4000_0fff, 32'h4000_4fff, 32'h4000_5fff, 32'h4000_6fff,
    32'h4000_7fff, 32'h4000_8fff, 32'h4000_cfff, 32'h4000_dfff,
    32'h4002_07ff, 32'h4002_0fff, 32'h4002_7fff, 32'h4003_0fff,
    32'h4003_1fff, 32'h4003_2fff, 32'h4003_cfff, 32'h400f_dfff,
    32'h400f_ffff};

  // transfer kind toward the selected slave
  typedef enum logic [1:0] {
    SAD_XFER_NONE  = 2'b00,
    SAD_XFER_WORD  = 2'b01,
    SAD_XFER_BIT   = 2'b10,
    SAD_XFER_FAULT = 2'b11
  } sad_xfer_t;

  // bit-band sequencer states
  typedef enum logic [1:0] {
    SAD_IDLE = 2'b00,
    SAD_WAIT = 2'b01,
    SAD_RMW  = 2'b10,
    SAD_DONE = 2'b11
  } sad_state_t;

  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

endpackage

//--- src/sad_region_map.sv
// combinational region decode of one address
// assumes the caller registers the results
`timescale 1ns/10ps
`default_nettype none
module sad_region_map
  import sad_pkg::*;
(
  // address in
  input  wire logic [31:0]        addr,
  // decode out
  output logic [NUM_SEL-1:0]      sel,
  output logic [31:0]             offset,
  output logic                    is_alias,
  output logic [31:0]             target_addr,
  output logic [4:0]              target_bit,
  output logic                    fault
);

  logic [NUM_PERI-1:0] peri_hit;
  logic [31:0]         alias_base;
  logic [31:0]         band_base;
  logic [24:0]         alias_off;

  // one comparator per peripheral window
  genvar g;
  generate
    for (g = 0; g < NUM_PERI; g++)
    begin : g_peri
      assign peri_hit[g] = in_range(addr, PERI_TAB_BASE[g], PERI_TAB_LAST[g]);
    end
  endgenerate

  // region select and offset toward the slave
  always_comb
  begin
    sel         = '0;
    offset      = '0;
    is_alias    = 1'b0;
    alias_base  = '0;
    band_base   = '0;
    if (in_range(addr, FLASH_BASE, FLASH_LAST))
    begin
      sel[SEL_FLASH] = 1'b1;
      offset         = addr - FLASH_BASE;
    end
    else if (in_range(addr, SRAM_BASE, SRAM_LAST))
    begin
      sel[SEL_SRAM] = 1'b1;
      offset        = addr - SRAM_BASE;
    end
    else if (in_range(addr, SRAM_ALIAS_BASE, SRAM_ALIAS_LAST))
    begin
      is_alias   = 1'b1;
      alias_base = SRAM_ALIAS_BASE;
      band_base  = SRAM_BASE;
    end
    else if (in_range(addr, PERI_ALIAS_BASE, PERI_ALIAS_LAST))
    begin
      is_alias   = 1'b1;
      alias_base = PERI_ALIAS_BASE;
      band_base  = PERI_BASE;
    end
    else if (in_range(addr, ITU_BASE, ITU_LAST))
    begin
      sel[SEL_ITU] = 1'b1;
      offset       = addr - ITU_BASE;
    end
    else if (in_range(addr, WTU_BASE, WTU_LAST))
    begin
      sel[SEL_WTU] = 1'b1;
      offset       = addr - WTU_BASE;
    end
    else if (in_range(addr, PBU_BASE, PBU_LAST))
    begin
      sel[SEL_PBU] = 1'b1;
      offset       = addr - PBU_BASE;
    end
    else if (in_range(addr, VIC_BASE, VIC_LAST))
    begin
      sel[SEL_VIC] = 1'b1;
      offset       = addr - VIC_BASE;
    end
    else if (in_range(addr, TPU_BASE, TPU_LAST))
    begin
      sel[SEL_TPU] = 1'b1;
      offset       = addr - TPU_BASE;
    end
    else
    begin
      for (int i = 0; i < NUM_PERI; i++)
      begin
        if (peri_hit[i])
        begin
          sel[SEL_WDOG + i] = 1'b1;
          offset            = addr - PERI_TAB_BASE[i];
        end
      end
    end
  end

  // alias word to target word address and bit number
  always_comb
  begin
    // both alias windows span 32 MB, so the low 25 bits hold the whole offset
    alias_off   = 25'(addr - alias_base);
    target_addr = band_base + {12'h000, alias_off[24:ALIAS_BYTE_LSB+2], 2'b00};
    target_bit  = {alias_off[ALIAS_BYTE_LSB+1:ALIAS_BYTE_LSB],
                   alias_off[ALIAS_BYTE_LSB-1:ALIAS_BIT_LSB]};
    if (!is_alias)
    begin
      target_addr = '0;
      target_bit  = '0;
    end
  end

  // vendor space and every hole fault; alias words never fault here, the decoder checks their target
  assign fault = ~(|sel) & ~is_alias;

endmodule // sad_region_map
`default_nettype wire

//--- src/sad_bitband.sv
// bit-band read-modify-write sequencer
// assumes the slave answers a word access with a one-cycle ready
`timescale 1ns/10ps
`default_nettype none
module sad_bitband
  import sad_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // alias request
  input  wire logic        start,
  input  wire logic        write,
  input  wire logic        wbit,
  input  wire logic [4:0]  bitpos,
  // slave word answer
  input  wire logic        slv_ready,
  input  wire logic [31:0] slv_rdata,
  // word phases toward slave
  output logic             wr_phase,
  output logic [31:0]      wr_word,
  // result
  output logic             done,
  output logic [31:0]      rdata
);

  sad_state_t  state;
  sad_state_t  next_state;
  logic [31:0] word;
  logic [31:0] next_word;

  // read the word first, then on a write put it back with one bit changed
  always_comb
  begin
    next_state = state;
    next_word  = word;
    case (state)
      SAD_IDLE:
        if (start)
          next_state = SAD_WAIT;
      SAD_WAIT:
        if (slv_ready)
        begin
          next_word = slv_rdata;
          if (write)
          begin
            next_word[bitpos] = wbit;
            next_state        = SAD_RMW;
          end
          else
            next_state = SAD_DONE;
        end
      SAD_RMW:
        if (slv_ready)
          next_state = SAD_DONE;
      SAD_DONE:
        next_state = SAD_IDLE;
      default:
        next_state = SAD_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= SAD_IDLE;
      word  <= '0;
    end
    else
    begin
      state <= next_state;
      word  <= next_word;
    end
  end

  assign wr_phase = (state == SAD_RMW);
  assign wr_word  = word;
  assign done     = (state == SAD_DONE);
  assign rdata    = {31'h0000_0000, word[bitpos]};

endmodule // sad_bitband
`default_nettype wire

//--- sim/sad_slave_model.sv
// slave side model: word memory answering selected word accesses
// assumes one select at a time, held until the answer is taken
`timescale 1ns/10ps
`default_nettype none
module sad_slave_model
  import sad_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               resetn,
  // from the decoder
  input  wire logic [NUM_SEL-1:0] slv_sel,
  input  wire logic               slv_write,
  input  wire logic [31:0]        slv_offset,
  input  wire logic [31:0]        slv_wdata,
  // answer speed
  input  wire logic               slow,
  // answer
  output logic                    slv_ready,
  output logic [31:0]             slv_rdata
);
  logic [31:0] mem [16];
  logic [2:0]  cnt;
  logic        served;
  logic        served_wr;

  // one answer per phase; a new phase is a change of write level
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt <= 3'h0;
      served <= 1'b0;
      served_wr <= 1'b0;
      slv_ready <= 1'b0;
      slv_rdata <= 32'h0;
      for (int i = 0; i < 16; i++) mem[i] <= 32'h0;
    end
    else
    begin
      slv_ready <= 1'b0;
      slv_rdata <= ~slv_rdata; // no stale data between answers
      if (slv_sel == '0)
      begin
        served <= 1'b0;
        cnt <= 3'h0;
      end
      else if (!slv_ready && (!served || served_wr != slv_write))
      begin
        if (cnt == (slow ? 3'h3 : 3'h0))
        begin
          slv_ready <= 1'b1;
          served <= 1'b1;
          served_wr <= slv_write;
          cnt <= 3'h0;
          if (slv_write) mem[slv_offset[5:2]] <= slv_wdata;
          else slv_rdata <= mem[slv_offset[5:2]];
        end
        else cnt <= cnt + 3'h1;
      end
    end
  end
endmodule // sad_slave_model
`default_nettype wire

//--- sim/sad_decoder_chk.sv
// checker for the decoder ports, attached by bind
// assumes requests are held until rsp_done
`timescale 1ns/10ps
`default_nettype none
module sad_decoder_chk
  import sad_pkg::*;
(
  // clock and reset
  input wire logic               clk,
  input wire logic               resetn,
  // processor side
  input wire logic               req,
  input wire logic               req_write,
  input wire logic [31:0]        req_addr,
  input wire logic [31:0]        req_wdata,
  input wire logic               rsp_done,
  input wire logic               rsp_fault,
  input wire logic [31:0]        rsp_rdata,
  // slave side
  input wire logic [NUM_SEL-1:0] slv_sel,
  input wire logic               slv_write,
  input wire logic [31:0]        slv_offset,
  input wire logic [31:0]        slv_wdata,
  input wire logic               slv_ready,
  input wire logic [31:0]        slv_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic        busy_q;
  logic        alias_q;
  logic [31:0] fetched_q;
  logic [4:0]  pos_q;
  logic        take;
  assign take = req && !busy_q && !rsp_done;

  // transfer tracking, alias flag and the fetched word of a bit access
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      busy_q <= 1'b0;
      alias_q <= 1'b0;
      fetched_q <= 32'h0;
      pos_q <= 5'h00;
    end
    else
    begin
      busy_q <= take ? 1'b1 : (rsp_done ? 1'b0 : busy_q);
      // the address may move on in the done cycle, so keep the bit number
      if (take) pos_q <= req_addr[6:2];
      if (take) alias_q <= in_range(req_addr, SRAM_ALIAS_BASE, SRAM_ALIAS_LAST) ||
                           in_range(req_addr, PERI_ALIAS_BASE, PERI_ALIAS_LAST);
      if (slv_ready && alias_q && !slv_write) fetched_q <= slv_rdata;
    end
  end

  sequence s_fetch;
    slv_ready && alias_q && busy_q && !slv_write;
  endsequence
  sequence s_wb;
    slv_write && slv_wdata == ((fetched_q & ~(32'h1 << pos_q)) |
                               ({31'h0, req_wdata[0]} << pos_q));
  endsequence
  property p_sel(lo, hi, int idx);
    take && in_range(req_addr, lo, hi) |=>
      slv_sel == (1 << idx) && slv_offset == $past(req_addr) - lo;
  endproperty

  AST_FAULT_VEND: assert property (take && req_addr >= VEND_BASE |->
    ##2 rsp_done && rsp_fault) else $error("vendor space did not fault");
  AST_FAULT_FLASH: assert property (take && in_range(req_addr, 32'h0000_4000, CODE_LAST)
    |-> ##2 rsp_done && rsp_fault) else $error("unbacked flash did not fault");
  AST_FAULT_GAP: assert property (take && in_range(req_addr, 32'h2400_0000, 32'h3fff_ffff)
    |-> ##2 rsp_done && rsp_fault) else $error("unmapped space did not fault");
  AST_FAULT_DONE: assert property (rsp_fault |-> rsp_done) else $error("fault without done");
  AST_DONE_PULSE: assert property (rsp_done |=> !rsp_done) else $error("done too long");
  AST_FLASH: assert property (p_sel(FLASH_BASE, FLASH_LAST, SEL_FLASH))
    else $error("flash select wrong");
  AST_SRAM: assert property (p_sel(SRAM_BASE, SRAM_LAST, SEL_SRAM)) else $error("sram select wrong");
  AST_ITU: assert property (p_sel(ITU_BASE, ITU_LAST, SEL_ITU)) else $error("itu select wrong");
  AST_WTU: assert property (p_sel(WTU_BASE, WTU_LAST, SEL_WTU)) else $error("wtu select wrong");
  AST_PBU: assert property (p_sel(PBU_BASE, PBU_LAST, SEL_PBU)) else $error("pbu select wrong");
  AST_VIC: assert property (p_sel(VIC_BASE, VIC_LAST, SEL_VIC)) else $error("vic select wrong");
  AST_TPU: assert property (p_sel(TPU_BASE, TPU_LAST, SEL_TPU)) else $error("tpu select wrong");
  for (genvar k = 0; k < NUM_PERI; k++)
  begin : g_peri
    AST_PERI: assert property (p_sel(PERI_TAB_BASE[k], PERI_TAB_LAST[k], SEL_WDOG + k))
      else $error("peripheral select wrong");
  end
  AST_SRAM_ALIAS: assert property (take &&
    in_range(req_addr, SRAM_ALIAS_BASE, 32'h2201_ffff) |=> slv_sel == (1 << SEL_SRAM) &&
    slv_offset == (($past(req_addr) - SRAM_ALIAS_BASE) >> 7) * 4)
    else $error("sram alias target wrong");
  AST_WORD_DONE: assert property (slv_ready && busy_q && !alias_q |=>
    rsp_done && !rsp_fault && slv_sel == '0 &&
    ($past(slv_write) || rsp_rdata == $past(slv_rdata))) else $error("word end wrong");
  AST_BIT_READ: assert property (s_fetch ##0 !req_write |-> ##[1:2] rsp_done &&
    rsp_rdata == ((fetched_q >> pos_q) & 32'h1)) else $error("bit read wrong");
  AST_BIT_WRITE: assert property (s_fetch ##0 req_write |-> ##[1:3] s_wb)
    else $error("bit write-back wrong");
endmodule // sad_decoder_chk
bind sad_decoder sad_decoder_chk sad_decoder_chk_inst (.clk(clk), .resetn(resetn), .req(req),
  .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_done(rsp_done),
  .rsp_fault(rsp_fault), .rsp_rdata(rsp_rdata), .slv_sel(slv_sel), .slv_write(slv_write),
  .slv_offset(slv_offset), .slv_wdata(slv_wdata), .slv_ready(slv_ready), .slv_rdata(slv_rdata));
`default_nettype wire

//--- sim/sad_decoder_tb.sv
// testbench for the decoder with the slave model behind it
// assumes the checker is bound in by its own file
`timescale 1ns/10ps
`default_nettype none
module sad_decoder_tb;
  import sad_pkg::*;
  typedef struct {logic [31:0] a; logic w; logic [31:0] d; logic f; int s;} sad_row_t;
  logic clk, resetn, req, req_write, rsp_done, rsp_fault, slv_write, slv_ready, slow;
  logic [31:0] req_addr, req_wdata, rsp_rdata, slv_offset, slv_wdata, slv_rdata;
  logic [NUM_SEL-1:0] slv_sel;
  logic [31:0] got_rd, got_off, got_wd, got_sel;
  logic got_f;
  int error_cnt = 0;
  int num_checks = 0;
  // reads compare rsp_rdata with d
  sad_row_t rows [16] = '{'{32'h0000_0010, 1, 32'hdead_beef, 0, 0},
    '{32'h0000_0010, 0, 32'hdead_beef, 0, 0}, '{32'h0000_3ffc, 0, 0, 0, 0},
    '{32'h0000_4000, 0, 0, 1, 0}, '{32'h2000_0ffc, 1, 32'hf0, 0, 1}, '{32'h2000_1000, 1, 0, 1, 0},
    '{32'h2400_0000, 0, 0, 1, 0}, '{32'h4000_1000, 0, 0, 1, 0}, '{32'he000_0004, 0, 0, 0, 19},
    '{32'he000_1ffc, 0, 32'hf0, 0, 20}, '{32'he000_2000, 0, 0, 0, 21},
    '{32'he000_e100, 0, 0, 0, 22}, '{32'he004_0ff0, 1, 32'h5, 0, 23},
    '{32'he000_3000, 0, 0, 1, 0}, '{32'he010_0000, 1, 0, 1, 0}, '{32'hffff_fffc, 0, 0, 1, 0}};

  sad_decoder sad_decoder_inst (.clk(clk), .resetn(resetn), .req(req), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_done(rsp_done), .rsp_fault(rsp_fault),
    .rsp_rdata(rsp_rdata), .slv_sel(slv_sel), .slv_write(slv_write), .slv_offset(slv_offset),
    .slv_wdata(slv_wdata), .slv_ready(slv_ready), .slv_rdata(slv_rdata));
  sad_slave_model sad_slave_model_inst (.clk(clk), .resetn(resetn), .slv_sel(slv_sel),
    .slv_write(slv_write), .slv_offset(slv_offset), .slv_wdata(slv_wdata), .slow(slow),
    .slv_ready(slv_ready), .slv_rdata(slv_rdata));

  // free running clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task print_verdict;
    if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // one transfer; hold keeps req up so the next one follows at once
  task xfer(input logic [31:0] a, input logic w, input logic [31:0] d, input logic hold);
    int n;
    @(negedge clk);
    req = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    got_sel = 32'h0;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
      if (slv_sel !== '0 && got_sel == 32'h0)
      begin
        got_sel = {8'h0, slv_sel};
        got_off = slv_offset;
      end
      if (slv_write === 1'b1) got_wd = slv_wdata;
    end
    while (rsp_done !== 1'b1 && n < 60);
    if (rsp_done !== 1'b1)
    begin
      error_cnt++;
      print_verdict();
    end
    got_rd = rsp_rdata;
    got_f = rsp_fault;
    if (!hold)
    begin
      @(negedge clk);
      req = 1'b0;
    end
  endtask

  // main sequence
  initial
  begin
    resetn = 1'b0;
    req = 1'b0;
    req_write = 1'b0;
    req_addr = 32'h0;
    req_wdata = 32'h0;
    slow = 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({8'h0, slv_sel} | {31'h0, rsp_done}, 32'h0);
    resetn = 1'b1;
    foreach (rows[i])
    begin
      xfer(rows[i].a, rows[i].w, rows[i].d, 1'b0);
      chk({31'h0, got_f}, {31'h0, rows[i].f});
      chk(got_sel, rows[i].f ? 32'h0 : 32'h1 << rows[i].s);
      if (!rows[i].w) chk(got_rd, rows[i].d);
    end
    for (int i = 0; i < NUM_PERI; i++)
    begin
      xfer(PERI_TAB_BASE[i] + 32'h8, 1'b0, 32'h0, 1'b0);
      chk(got_sel, 32'h1 << (SEL_WDOG + i));
      chk(got_off, 32'h8);
      xfer(PERI_TAB_LAST[i] - 32'h3, 1'b0, 32'h0, 1'b0);
      chk(got_off, PERI_TAB_LAST[i] - 32'h3 - PERI_TAB_BASE[i]);
    end
    // slow slave, back to back bit accesses
    slow = 1'b1;
    xfer(32'h2201_ff90, 1'b1, 32'h0, 1'b1);
    chk(got_off, 32'hffc);
    chk(got_wd, 32'he0);
    xfer(32'h2201_ff94, 1'b0, 32'h0, 1'b1);
    chk(got_rd, 32'h1);
    xfer(32'h2000_0ffc, 1'b0, 32'h0, 1'b0);
    chk(got_rd, 32'he0);
    xfer(32'h4200_0104, 1'b1, 32'h1, 1'b0);
    chk(got_sel, 32'h1 << SEL_WDOG);
    chk(got_off, 32'h8);
    xfer(32'h4000_0008, 1'b0, 32'h0, 1'b0);
    chk(got_rd, 32'h2);
    xfer(32'h2202_0000, 1'b0, 32'h0, 1'b0);
    chk({31'h0, got_f}, 32'h1);
    // reset in mid transfer: slv_sel, rsp_done and rsp_rdata drop and the next access still completes
    @(negedge clk);
    req = 1'b1;
    req_write = 1'b0;
    req_addr = 32'h2000_0ffc;
    @(posedge clk);
    @(negedge clk);
    resetn = 1'b0;
    req = 1'b0;
    @(negedge clk);
    chk({8'h0, slv_sel} | {31'h0, rsp_done} | rsp_rdata, 32'h0);
    resetn = 1'b1;
    xfer(32'h2000_0ffc, 1'b0, 32'h0, 1'b0);
    chk(got_sel, 32'h1 << SEL_SRAM);
    chk(got_rd, 32'h0);
    print_verdict();
  end
endmodule // sad_decoder_tb
`default_nettype wire
